// ==== dgo_pkg.sv ====
/*
 Constants, enumerations and reset values shared by the two-port digital output controller.
 Assumes a single 40 MHz system clock and that all control inputs are synchronous to it.
*/
// Function
// - each output picks its source: remote command, alarm association or energy pulsing.
// - under remote command the output follows on and off commands.
// - under alarm control an associated alarm trigger drives the output on.
// - energy pulsing emits pulses for a selected energy quantity at a set rate.
// - latching and coil hold apply only to command or alarm sources.
// - latching with commands: on command turns output on until an off command.
// - latching with alarms: output stays on until the alarm drops out.
// - timed: output turns on at a trigger, holds for on time, then off.
// - on time is whole seconds, 0 to 9999.
// - energy pulses are fixed 20 ms wide; the on-time setting is ignored.
// - coil hold: energize turns on, release turns off, nothing else acts.
// - coil hold state is retained and restored after power returns.
// - alarm control responds to any one of a selected set of alarms.
// - two independent outputs, each with its own configuration.
// - output pin defaults high after reset; idle level set through communication.
package dgo_pkg;

   localparam int NUM_OUT        = 2;
   localparam int CLK_HZ         = 40_000_000;
   localparam int TICK_MS        = 1;
   localparam int MS_CYCLES      = CLK_HZ / 1000 * TICK_MS;
   localparam int PULSE_WIDTH_MS = 20;
   localparam int MS_PER_S       = 1000;
   localparam int ON_TIME_MAX    = 9999;
   localparam int ON_TIME_W      = 14;
   localparam int MSC_W          = 10;
   localparam int PMS_W          = 5;

   localparam logic [PMS_W-1:0] PULSE_TICKS = PMS_W'(PULSE_WIDTH_MS / TICK_MS);
   localparam logic [MSC_W-1:0] MS_LAST     = MSC_W'(MS_PER_S / TICK_MS - 1);
   localparam logic             RST_PIN     = 1'b1;
   localparam logic             RST_ON      = 1'b0;

   typedef enum logic [1:0] {DGO_SRC_EXT, DGO_SRC_ALARM, DGO_SRC_ENERGY} dgo_src_e;
   typedef enum logic [1:0] {DGO_BEH_NORMAL, DGO_BEH_TIMED, DGO_BEH_COIL} dgo_beh_e;

endpackage

// ==== dgo_ms_tick.sv ====
/*
 Free-running millisecond tick generator for the digital output controller.
 Assumes clk_en freezes it together with the rest of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module dgo_ms_tick #(
   parameter int MS_CYCLES = dgo_pkg::MS_CYCLES,
   parameter int CNT_W     = $clog2(MS_CYCLES)
) (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic clk_en,
   output var  logic ms_tick
);
   import dgo_pkg::*;

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             next_tick;

   always_comb begin
      next_tick = 1'b0;
      next_cnt  = cnt + CNT_W'(1);
      if (cnt == CNT_W'(MS_CYCLES - 1)) begin
         next_cnt  = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt     <= '0;
         ms_tick <= 1'b0;
      end else if (clk_en) begin
         cnt     <= next_cnt;
         ms_tick <= next_tick;
      end
   end

endmodule
`default_nettype wire

// ==== dgo_output_ctrl.sv ====
/*
 Two-port digital output controller: command, alarm and energy-pulse sources,
 latching, timed and coil hold behaviour, pin polarity and retained coil state.
 Assumes commands and alarm levels are synchronous to sys_clk, and that an
 external retained store holds coil_state and presents it on retained_state.
*/
`timescale 1ns/1ps
`default_nettype none
module dgo_output_ctrl #(
   parameter int MS_CYCLES  = dgo_pkg::MS_CYCLES,
   parameter int NUM_ALARMS = 8,
   parameter int NUM_ENERGY = 4,
   parameter int ESEL_W     = $clog2(NUM_ENERGY),
   parameter int AMT_W      = 16,
   parameter int ACC_W      = 24
) (
   input  wire logic                           sys_clk,
   input  wire logic                           reset_n,
   input  wire logic                           clk_en,
   input  var  dgo_pkg::dgo_src_e              ctrl_src       [dgo_pkg::NUM_OUT],
   input  var  dgo_pkg::dgo_beh_e              behave_mode    [dgo_pkg::NUM_OUT],
   input  wire logic [dgo_pkg::ON_TIME_W-1:0]  on_time_s      [dgo_pkg::NUM_OUT],
   input  wire logic [NUM_ALARMS-1:0]          alarm_select   [dgo_pkg::NUM_OUT],
   input  wire logic [NUM_ALARMS-1:0]          alarm_active,
   input  wire logic [dgo_pkg::NUM_OUT-1:0]    cmd_on,
   input  wire logic [dgo_pkg::NUM_OUT-1:0]    cmd_off,
   input  wire logic [ESEL_W-1:0]              energy_sel     [dgo_pkg::NUM_OUT],
   input  wire logic [ACC_W-1:0]               pulse_quantum  [dgo_pkg::NUM_OUT],
   input  wire logic [NUM_ENERGY-1:0]          energy_valid,
   input  wire logic [AMT_W-1:0]               energy_amount  [NUM_ENERGY],
   input  wire logic [dgo_pkg::NUM_OUT-1:0]    idle_high,
   input  wire logic [dgo_pkg::NUM_OUT-1:0]    retained_state,
   output var  logic [dgo_pkg::NUM_OUT-1:0]    output_on,
   output var  logic [dgo_pkg::NUM_OUT-1:0]    coil_state,
   output var  logic                           switched_output_first,
   output var  logic                           switched_output_second
);
   import dgo_pkg::*;

   logic                  ms_tick;
   logic                  restored;
   logic                  next_restored;
   logic [NUM_OUT-1:0]    pin;

   dgo_ms_tick #(
      .MS_CYCLES (MS_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .ms_tick (ms_tick)
   );

   // first enabled cycle after reset reloads retained coil state
   always_comb begin
      next_restored = 1'b1;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         restored <= 1'b0;
      end else if (clk_en) begin
         restored <= next_restored;
      end
   end

   assign switched_output_first  = pin[0];
   assign switched_output_second = pin[1];

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      logic                 on_q;
      logic                 next_on;
      logic [ON_TIME_W-1:0] sec_left;
      logic [ON_TIME_W-1:0] next_sec;
      logic [MSC_W-1:0]     ms_cnt;
      logic [MSC_W-1:0]     next_ms;
      logic [PMS_W-1:0]     pls;
      logic [PMS_W-1:0]     next_pls;
      logic [ACC_W-1:0]     acc;
      logic [ACC_W-1:0]     next_acc;
      logic                 hit_q;
      logic                 next_pin;
      logic                 next_coil;
      logic                 hit;
      logic                 trig;
      logic                 drop;
      logic                 fire;
      logic [ACC_W:0]       sum;
      logic [ACC_W:0]       inc;
      logic [3:0]           cfg_q;
      logic                 steady;

      // any one selected alarm counts
      assign hit = |(alarm_active & alarm_select[i]);

      always_comb begin
         next_on   = on_q;
         next_sec  = sec_left;
         next_ms   = ms_cnt;
         next_pls  = pls;
         next_acc  = acc;
         trig      = 1'b0;
         drop      = 1'b0;
         fire      = 1'b0;
         inc       = '0;
         if (energy_valid[energy_sel[i]]) begin
            inc = (ACC_W+1)'(energy_amount[energy_sel[i]]);
         end
         sum = {1'b0, acc} + inc;
         if (!restored) begin
            // only coil hold outputs come back; others start off
            next_on = (behave_mode[i] == DGO_BEH_COIL && ctrl_src[i] != DGO_SRC_ENERGY)
                    ? retained_state[i] : RST_ON;
         end else if (ctrl_src[i] == DGO_SRC_ENERGY) begin
            // behaviour mode and on time are ignored here
            next_sec = '0;
            next_ms  = '0;
            next_acc = sum[ACC_W-1:0];
            if (pulse_quantum[i] != '0 && sum >= {1'b0, pulse_quantum[i]}) begin
               fire     = 1'b1;
               next_acc = ACC_W'(sum - {1'b0, pulse_quantum[i]});
            end
            // pulses closer than 20 ms merge: a new one restarts the width
            if (fire) begin
               next_pls = PULSE_TICKS;
            end else if (ms_tick && pls != '0) begin
               next_pls = pls - PMS_W'(1);
            end
            next_on = (next_pls != '0);
         end else begin
            next_pls = '0;
            if (ctrl_src[i] == DGO_SRC_EXT) begin
               trig = cmd_on[i];
               drop = cmd_off[i];
            end else begin
               trig = hit && !hit_q;
               drop = !hit;
            end
            case (behave_mode[i])
               DGO_BEH_TIMED: begin
                  if (trig) begin
                     next_sec = on_time_s[i];
                     next_ms  = '0;
                  end else if (ms_tick && sec_left != '0) begin
                     if (ms_cnt == MS_LAST) begin
                        next_ms  = '0;
                        next_sec = sec_left - ON_TIME_W'(1);
                     end else begin
                        next_ms = ms_cnt + MSC_W'(1);
                     end
                  end
                  next_on = (next_sec != '0);
               end
               DGO_BEH_COIL: begin
                  // only the release command clears it; alarm dropout does not
                  if (cmd_off[i]) begin
                     next_on = 1'b0;
                  end else if (trig) begin
                     next_on = 1'b1;
                  end
               end
               default: begin
                  // off wins when both arrive together
                  if (drop) begin
                     next_on = 1'b0;
                  end else if (trig) begin
                     next_on = 1'b1;
                  end
               end
            endcase
         end
         next_pin  = next_on ^ idle_high[i];
         next_coil = (behave_mode[i] == DGO_BEH_COIL && ctrl_src[i] != DGO_SRC_ENERGY)
                   ? next_on : coil_state[i];
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            on_q          <= RST_ON;
            sec_left      <= '0;
            ms_cnt        <= '0;
            pls           <= '0;
            acc           <= '0;
            hit_q         <= 1'b0;
            pin[i]        <= RST_PIN;
            coil_state[i] <= 1'b0;
            output_on[i]  <= RST_ON;
         end else if (clk_en) begin
            on_q          <= next_on;
            sec_left      <= next_sec;
            ms_cnt        <= next_ms;
            pls           <= next_pls;
            acc           <= next_acc;
            hit_q         <= hit;
            pin[i]        <= next_pin;
            coil_state[i] <= next_coil;
            output_on[i]  <= next_on;
         end
      end

      // assertion helper: configuration unchanged since last cycle
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            cfg_q <= '0;
         end else begin
            cfg_q <= {ctrl_src[i], behave_mode[i]};
         end
      end
      assign steady = (cfg_q == {ctrl_src[i], behave_mode[i]}) && restored;

      sequence s_ext_normal;
         steady && clk_en && ctrl_src[i] == DGO_SRC_EXT && behave_mode[i] == DGO_BEH_NORMAL;
      endsequence

      sequence s_timed_trig;
         steady && clk_en && ctrl_src[i] != DGO_SRC_ENERGY && behave_mode[i] == DGO_BEH_TIMED
            && trig;
      endsequence

      a_pin_polarity: assert property (
         $past(clk_en) && $past(restored) |-> pin[i] == (on_q ^ $past(idle_high[i])))
         else $error("output pin level does not match state and idle level");

      a_ext_latch_on: assert property (
         s_ext_normal ##0 (cmd_on[i] && !cmd_off[i]) |=> on_q ##1 (on_q || $past(cmd_off[i])))
         else $error("command latch did not turn on or hold");

      a_ext_off_cmd: assert property (
         s_ext_normal ##0 cmd_off[i] |=> !on_q)
         else $error("off command did not turn output off");

      a_alarm_dropout: assert property (
         steady && clk_en && ctrl_src[i] == DGO_SRC_ALARM && behave_mode[i] == DGO_BEH_NORMAL
            && !hit |=> !on_q)
         else $error("alarm output stayed on after dropout");

      a_alarm_trigger: assert property (
         steady && clk_en && ctrl_src[i] == DGO_SRC_ALARM && behave_mode[i] != DGO_BEH_TIMED
            && hit && !hit_q && !cmd_off[i] |=> on_q)
         else $error("alarm trigger did not turn output on");

      a_timed_restart: assert property (
         s_timed_trig |=> sec_left == $past(on_time_s[i]) && ms_cnt == '0
            && on_q == (sec_left != '0))
         else $error("timed trigger did not load on time");

      a_timed_level: assert property (
         steady && ctrl_src[i] != DGO_SRC_ENERGY && behave_mode[i] == DGO_BEH_TIMED
            |-> on_q == (sec_left != '0))
         else $error("timed output level disagrees with remaining time");

      a_coil_holds: assert property (
         steady && clk_en && ctrl_src[i] != DGO_SRC_ENERGY && behave_mode[i] == DGO_BEH_COIL
            && on_q && !cmd_off[i] |=> on_q && coil_state[i])
         else $error("coil hold output dropped without release");

      a_energy_width: assert property (
         steady && clk_en && ctrl_src[i] == DGO_SRC_ENERGY && fire
            |=> pls == PULSE_TICKS && on_q)
         else $error("energy pulse did not start at full width");

      a_energy_acc: assert property (
         steady && clk_en && ctrl_src[i] == DGO_SRC_ENERGY && !fire
            |=> acc == $past(sum[ACC_W-1:0]))
         else $error("energy accumulator lost an increment");
   end

endmodule
`default_nettype wire

// ==== dgo_pulse_rx.sv ====
/*
 Receiver model standing at one switched output pin: counts active spans.
 Assumes the pin is registered on sys_clk and the idle level stays steady.
*/
`timescale 1ns/1ps
`default_nettype none
module dgo_pulse_rx (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic pin,
   input  wire logic idle_level,
   output var  int   pulse_count,
   output var  int   last_width
);
   int run;
   // a span still open at reset is dropped, as a counter losing power would
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         run         <= 0;
         pulse_count <= 0;
         last_width  <= 0;
      end else if (pin !== idle_level) begin
         run <= run + 1;
      end else if (run > 0) begin
         last_width  <= run;
         pulse_count <= pulse_count + 1;
         run         <= 0;
      end
   end
endmodule
`default_nettype wire

// ==== testbench.sv ====
/*
 Self-checking bench for the two-port output controller, with a model per port.
 Assumes a short millisecond tick (MSC cycles) and no real retained store.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dgo_pkg::*;
   localparam int MSC = 4;
   logic                 sys_clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 clk_en = 1'b1;
   dgo_src_e             ctrl_src [NUM_OUT];
   dgo_beh_e             behave_mode [NUM_OUT];
   logic [ON_TIME_W-1:0] on_time_s [NUM_OUT];
   logic [7:0]           alarm_select [NUM_OUT];
   logic [7:0]           alarm_active = 8'h00;
   logic [1:0]           cmd_on = 2'h0;
   logic [1:0]           cmd_off = 2'h0;
   logic [1:0]           energy_sel [NUM_OUT];
   logic [23:0]          pulse_quantum [NUM_OUT];
   logic [3:0]           energy_valid = 4'h0;
   logic [15:0]          energy_amount [4];
   logic [1:0]           idle_high = 2'h1;
   logic [1:0]           retained_state = 2'h0;
   logic [1:0]           output_on;
   logic [1:0]           coil_state;
   logic                 switched_output_first;
   logic                 switched_output_second;
   int                   cnt0, cnt1, wid0, wid1, acc, exp_cnt, base;
   int                   miscompares = 0;
   int                   check_count = 0;
   int                   exp_on [2];
   logic [7:0]           alv [5] = '{8'h04, 8'h06, 8'h04, 8'h0c, 8'h00};
   int                   alx [5] = '{0, 1, 0, 1, 0};
   logic [31:0]          rnd = 32'h618a2ac7;

   dgo_output_ctrl #(.MS_CYCLES(MSC)) uut (
      .sys_clk, .reset_n, .clk_en, .ctrl_src, .behave_mode, .on_time_s, .alarm_select,
      .alarm_active, .cmd_on, .cmd_off, .energy_sel, .pulse_quantum, .energy_valid,
      .energy_amount, .idle_high, .retained_state, .output_on, .coil_state,
      .switched_output_first, .switched_output_second);
   dgo_pulse_rx rx0 (.sys_clk(sys_clk), .reset_n(reset_n), .pin(switched_output_first),
      .idle_level(idle_high[0]), .pulse_count(cnt0), .last_width(wid0));
   dgo_pulse_rx rx1 (.sys_clk(sys_clk), .reset_n(reset_n), .pin(switched_output_second),
      .idle_level(idle_high[1]), .pulse_count(cnt1), .last_width(wid1));

   task automatic close_out();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input int p);
      chk_bit(output_on[p], exp_on[p][0]);
      chk_bit(p == 0 ? switched_output_first : switched_output_second,
              exp_on[p][0] ^ idle_high[p]);
   endtask
   task automatic chk_span(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic pulse(input int p, input bit off);
      @(negedge sys_clk);
      if (off) begin
         cmd_off[p] = 1'b1;
      end else begin
         cmd_on[p] = 1'b1;
      end
      @(negedge sys_clk);
      cmd_on = 2'h0;
      cmd_off = 2'h0;
   endtask
   task automatic set_alarm(input logic [7:0] v);
      @(negedge sys_clk);
      alarm_active = v;
      @(negedge sys_clk);
   endtask
   // bounded: a stuck output ends the run instead of hanging it
   task automatic wait_off(input int p, input int bound);
      int n;
      n = 0;
      while (output_on[p] !== 1'b0) begin
         @(negedge sys_clk);
         n++;
         if (n > bound) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, output_on[p], 1'b0);
            close_out();
         end
      end
      // receiver logs the span one edge after the pin falls back
      @(negedge sys_clk);
   endtask
   task automatic power_cycle();
      @(negedge sys_clk);
      reset_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk_bit(switched_output_first, RST_PIN);
      chk_bit(switched_output_second, RST_PIN);
      reset_n = 1'b1;
      repeat (2) @(negedge sys_clk);
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial begin
      for (int p = 0; p < 2; p++) begin
         ctrl_src[p] = DGO_SRC_EXT;
         behave_mode[p] = DGO_BEH_NORMAL;
         on_time_s[p] = 14'h0001;
         alarm_select[p] = 8'h00;
         energy_sel[p] = 2'h2;
         pulse_quantum[p] = 24'h00000a;
         exp_on[p] = 0;
      end
      for (int i = 0; i < 4; i++) begin
         energy_amount[i] = 16'h0000;
      end
      // port 1 idles low, set as if by communication
      idle_high = 2'h1;
      power_cycle();
      chk_out(1);
      // a command seen while clk_en is low must be ignored
      clk_en = 1'b0;
      pulse(0, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk_out(0);
      clk_en = 1'b1;
      for (int p = 0; p < 2; p++) begin
         pulse(p, 1'b0);
         exp_on[p] = 1;
         chk_out(p);
         repeat (10) @(negedge sys_clk);
         chk_out(p);
         pulse(p, 1'b1);
         exp_on[p] = 0;
         chk_out(p);
      end
      ctrl_src[0] = DGO_SRC_ALARM;
      alarm_select[0] = 8'h0a;
      foreach (alv[i]) begin
         set_alarm(alv[i]);
         exp_on[0] = alx[i];
         chk_out(0);
         chk_out(1);
      end
      behave_mode[1] = DGO_BEH_TIMED;
      on_time_s[1] = 14'h0000;
      pulse(1, 1'b0);
      chk_out(1);
      on_time_s[1] = 14'h0001;
      pulse(1, 1'b0);
      repeat (2000) @(negedge sys_clk);
      pulse(1, 1'b0);
      pulse(1, 1'b1);
      exp_on[1] = 1;
      chk_out(1);
      wait_off(1, 5000);
      exp_on[1] = 0;
      chk_span(wid1, 5998, 6004);
      // a unary alarm output is configured for coil hold
      behave_mode[0] = DGO_BEH_COIL;
      alarm_select[0] = 8'h01;
      set_alarm(8'h01);
      set_alarm(8'h00);
      exp_on[0] = 1;
      chk_out(0);
      chk_bit(coil_state[0], 1'b1);
      pulse(0, 1'b1);
      exp_on[0] = 0;
      chk_out(0);
      set_alarm(8'h01);
      set_alarm(8'h00);
      exp_on[0] = 1;
      retained_state = {exp_on[1][0], exp_on[0][0]};
      power_cycle();
      chk_out(0);
      chk_out(1);
      pulse(0, 1'b1);
      exp_on[0] = 0;
      chk_out(0);
      retained_state = 2'h0;
      ctrl_src[0] = DGO_SRC_ENERGY;
      behave_mode[0] = DGO_BEH_TIMED;
      pulse(0, 1'b0);
      chk_out(0);
      acc = 0;
      exp_cnt = 0;
      base = cnt0;
      repeat (8) begin
         rnd = lfsr(rnd);
         @(negedge sys_clk);
         energy_amount[2] = {13'h0000, rnd[2:0]} + 16'h0003;
         energy_amount[1] = rnd[31:16];
         energy_valid = 4'h6;
         @(negedge sys_clk);
         energy_valid = 4'h0;
         acc += energy_amount[2];
         exp_on[0] = (acc >= 10);
         if (acc >= 10) begin
            acc -= 10;
         end
         chk_out(0);
         if (exp_on[0] == 1) begin
            wait_off(0, 200);
            exp_cnt++;
            chk_span(wid0, 76, 81);
         end
         exp_on[0] = 0;
      end
      chk_span(cnt0 - base, exp_cnt, exp_cnt);
      close_out();
   end
endmodule
`default_nettype wire
